/* rtl/aic_capture_top.sv */
// Analog input capture: register port, phase clock edges, converter link
`timescale 1ns/100ps
module aic_capture_top #(
    parameter int PHASE_HALF_CYCLES = aic_pkg::PHASE_HALF_CYCLES_DEF,
    parameter int SERVO_PHASES = aic_pkg::SERVO_PHASES_DEF
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic [aic_pkg::ADDR_W-1:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [31:0] bus_rdata_out,
    input wire logic [aic_pkg::UNIT_W-1:0] addr_switch_in,
    input wire logic phase_clk_in,
    output logic phase_clk_out,
    output logic phase_clk_oe_out,
    output logic servo_clk_out,
    output logic servo_clk_oe_out,
    output logic [aic_pkg::FILTER_BITS-1:0] filter_code_out,
    output logic [31:0] io_data_out,
    output logic [31:0] io_oe_out,
    output aic_pkg::aic_conv_cfg_t conv_cfg_out,
    input wire logic link_clk_in,
    output logic conv_start_out,
    output logic conv_group_b_out,
    input wire logic conv_valid_in,
    input wire logic [1:0] conv_slot_in,
    input wire logic [aic_pkg::SAMPLE_W-1:0] conv_data_in
);
    import aic_pkg::*;

    localparam int PH_CNT_W = $clog2(PHASE_HALF_CYCLES + 1);
    localparam int SV_CNT_W = $clog2(SERVO_PHASES + 1);

    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [1:0] link_rst_r;
    logic link_rst_n;
    logic [2:0][UNIT_W-1:0] sw_sync_r;
    logic [UNIT_W-1:0] unit_r;
    logic [2:0] ph_sync_r;
    logic phase_lvl_r;
    logic phase_rise;
    logic phase_fall;
    logic [PH_CNT_W-1:0] ph_cnt_r;
    logic ph_gen_r;
    logic [SV_CNT_W-1:0] sv_cnt_r;
    logic servo_r;
    logic is_source;
    logic [31:0] result_r [NUM_INPUTS];
    logic [31:0] filter_r;
    logic [31:0] io_dir_r;
    logic [31:0] io_pol_r;
    logic [31:0] io_ctrl_r;
    logic [3:0] clk_src_r;
    aic_conv_cfg_t cfg_r;
    logic unit_sel;
    logic [7:0] ofs;
    logic [31:0] rd_mux;
    logic rise_l;
    logic fall_l;
    logic [GROUP_SIZE-1:0] mask_r;
    logic done_r;
    aic_group_t gather_r;
    logic xfer_busy;
    logic xfer_load;
    logic xfer_valid;
    aic_group_t xfer_data;
    logic [31:0] io_drive;

    // Reset release through two flops in each domain
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            link_rst_r <= 2'h0;
        else
            link_rst_r <= {link_rst_r[0], 1'b1};
    end
    assign link_rst_n = link_rst_r[1];

    // Address switch: taken once two late stages agree
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sw_sync_r <= '0;
            unit_r <= '0;
        end else begin
            sw_sync_r <= {sw_sync_r[1:0], addr_switch_in};
            if (sw_sync_r[2] == sw_sync_r[1])
                unit_r <= sw_sync_r[2];
        end
    end

    // Phase clock edges, each counted once the late stages agree
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ph_sync_r <= 3'h0;
            phase_lvl_r <= 1'b0;
        end else begin
            ph_sync_r <= {ph_sync_r[1:0], phase_clk_in};
            if (ph_sync_r[2] == ph_sync_r[1])
                phase_lvl_r <= ph_sync_r[2];
        end
    end
    assign phase_rise = (ph_sync_r[2] == ph_sync_r[1]) && ph_sync_r[2] && !phase_lvl_r;
    assign phase_fall = (ph_sync_r[2] == ph_sync_r[1]) && !ph_sync_r[2] && phase_lvl_r;

    // Clock source: from reset until its switch is taken every unit drives the shared clock lines, then only the chosen unit
    assign is_source = (clk_src_r == unit_r);

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ph_cnt_r <= '0;
            ph_gen_r <= 1'b0;
            sv_cnt_r <= '0;
            servo_r <= 1'b0;
        end else if (ph_cnt_r == PH_CNT_W'(PHASE_HALF_CYCLES - 1)) begin
            ph_cnt_r <= '0;
            ph_gen_r <= ~ph_gen_r;
            if (!ph_gen_r) begin
                if (sv_cnt_r == SV_CNT_W'(SERVO_PHASES - 1)) begin
                    sv_cnt_r <= '0;
                    servo_r <= 1'b1;
                end else begin
                    sv_cnt_r <= sv_cnt_r + 1'b1;
                    servo_r <= 1'b0;
                end
            end
        end else begin
            ph_cnt_r <= ph_cnt_r + 1'b1;
        end
    end
    assign phase_clk_out = ph_gen_r;
    assign phase_clk_oe_out = is_source;
    assign servo_clk_out = servo_r;
    assign servo_clk_oe_out = is_source;

    // Register port decode; a foreign unit index reads as zero
    assign unit_sel = (bus_addr_in[UNIT_LSB +: UNIT_W] == unit_r);
    assign ofs = bus_addr_in[7:0];

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            filter_r <= 32'h0;
            io_dir_r <= IO_DIR_RST;
            io_pol_r <= IO_POL_RST;
            io_ctrl_r <= IO_CTRL_RST;
            clk_src_r <= CLK_SRC_RST;
            cfg_r.clock_div <= CLK_DIV_RST;
            cfg_r.control <= CONV_CTRL_RST;
            cfg_r.strobe <= STROBE_RST;
            cfg_r.header_bits <= HEADER_RST;
            cfg_r.delay <= DELAY_RST;
            cfg_r.utos <= UTOS_RST;
        end else if (bus_wr_in && unit_sel) begin
            unique case (ofs)
                OFS_FILTER: filter_r <= bus_wdata_in;
                OFS_IO_DIR: io_dir_r <= bus_wdata_in;
                OFS_IO_POL: io_pol_r <= bus_wdata_in;
                OFS_IO_CTRL: io_ctrl_r <= bus_wdata_in;
                OFS_CLK_SRC: clk_src_r <= bus_wdata_in[3:0];
                OFS_CLK_DIV: cfg_r.clock_div <= bus_wdata_in[7:0];
                OFS_CONV_CTRL: cfg_r.control <= bus_wdata_in;
                OFS_STROBE: cfg_r.strobe <= bus_wdata_in;
                OFS_HEADER: cfg_r.header_bits <= bus_wdata_in[7:0];
                OFS_DELAY: cfg_r.delay <= bus_wdata_in[7:0];
                OFS_UTOS: cfg_r.utos <= bus_wdata_in[0];
                default: ;
            endcase
        end
    end
    assign conv_cfg_out = cfg_r;

    always_comb begin
        rd_mux = 32'h0;
        if (ofs < OFS_FILTER && ofs[1:0] == 2'b00) begin
            rd_mux = result_r[ofs[4:2]];
        end else begin
            unique case (ofs)
                OFS_FILTER: rd_mux = filter_r;
                OFS_IO_DIR: rd_mux = io_dir_r;
                OFS_IO_POL: rd_mux = io_pol_r;
                OFS_IO_CTRL: rd_mux = io_ctrl_r;
                OFS_CLK_SRC: rd_mux = {28'h0, clk_src_r};
                OFS_CLK_DIV: rd_mux = {24'h0, cfg_r.clock_div};
                OFS_CONV_CTRL: rd_mux = cfg_r.control;
                OFS_STROBE: rd_mux = cfg_r.strobe;
                OFS_HEADER: rd_mux = {24'h0, cfg_r.header_bits};
                OFS_DELAY: rd_mux = {24'h0, cfg_r.delay};
                OFS_UTOS: rd_mux = {31'h0, cfg_r.utos};
                OFS_STATUS: begin
                    rd_mux[ST_UNIT_LSB +: UNIT_W] = unit_r;
                    rd_mux[ST_SOURCE_BIT] = is_source;
                    rd_mux[ST_PHASE_BIT] = phase_lvl_r;
                end
                default: rd_mux = 32'h0;
            endcase
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n)
            bus_rdata_out <= 32'h0;
        else if (bus_rd_in && unit_sel)
            bus_rdata_out <= rd_mux;
        else
            bus_rdata_out <= 32'h0;
    end

    // Io word drives only the bits marked outward; low half sets filters
    assign io_drive = filter_r ^ io_pol_r;
    assign io_data_out = io_drive;
    assign io_oe_out = io_dir_r;
    assign filter_code_out = io_drive[FILTER_BITS-1:0] & io_dir_r[FILTER_BITS-1:0];

    // Phase edges handed to the converter clock
    aic_pulse_sync u_rise_sync (
        .src_clk_in(sys_clk_in),
        .src_rst_n_in(rst_n),
        .src_pulse_in(phase_rise),
        .dst_clk_in(link_clk_in),
        .dst_rst_n_in(link_rst_n),
        .dst_pulse_out(rise_l)
    );

    aic_pulse_sync u_fall_sync (
        .src_clk_in(sys_clk_in),
        .src_rst_n_in(rst_n),
        .src_pulse_in(phase_fall),
        .dst_clk_in(link_clk_in),
        .dst_rst_n_in(link_rst_n),
        .dst_pulse_out(fall_l)
    );

    // Converter side: start a group, gather its four samples
    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            conv_start_out <= 1'b0;
            conv_group_b_out <= 1'b0;
            mask_r <= '0;
            done_r <= 1'b0;
            gather_r <= '0;
        end else begin
            conv_start_out <= rise_l || fall_l;
            if (rise_l || fall_l) begin
                conv_group_b_out <= fall_l;
                gather_r.group_b <= fall_l;
                mask_r <= '0;
                done_r <= 1'b0;
            end else begin
                if (conv_valid_in) begin
                    gather_r.data[conv_slot_in] <= conv_data_in;
                    mask_r[conv_slot_in] <= 1'b1;
                end
                if (xfer_load)
                    done_r <= 1'b1;
            end
        end
    end

    // A group waits here while the previous one is still crossing
    assign xfer_load = (mask_r == '1) && !done_r && !rise_l && !fall_l && !xfer_busy;

    aic_word_xfer #(
        .W($bits(aic_group_t))
    ) u_group_xfer (
        .src_clk_in(link_clk_in),
        .src_rst_n_in(link_rst_n),
        .src_load_in(xfer_load),
        .src_data_in(gather_r),
        .src_busy_out(xfer_busy),
        .dst_clk_in(sys_clk_in),
        .dst_rst_n_in(rst_n),
        .dst_valid_out(xfer_valid),
        .dst_data_out(xfer_data)
    );

    // Results replaced only when a whole group has arrived
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_INPUTS; i++)
                result_r[i] <= 32'h0;
        end else if (xfer_valid) begin
            for (int s = 0; s < GROUP_SIZE; s++)
                result_r[input_of(xfer_data.group_b, 2'(s))] <=
                    {condition_code(xfer_data.data[s], cfg_r.utos), 16'h0};
        end
    end

    sequence s_group_lands;
        xfer_valid;
    endsequence

    a_result_range: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $signed(result_r[0][31:16]) >= $signed(CODE_MIN)
        && $signed(result_r[7][31:16]) <= $signed(CODE_MAX))
        else $error("result outside code range");
    a_signed_update: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (s_group_lands and !cfg_r.utos) ##1 1'b1 |->
        result_r[$past(input_of(xfer_data.group_b, 2'h0))][31:16]
        == condition_code($past(xfer_data.data[0]), 1'b0))
        else $error("signed sample not stored");
    a_low_half_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        result_r[3][15:0] == 16'h0 && result_r[4][15:0] == 16'h0)
        else $error("result low half not zero");
    a_results_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !xfer_valid |=> $stable(result_r[0]) && $stable(result_r[2]) && $stable(result_r[5]))
        else $error("result changed without a conversion");
    a_rise_group_a: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        rise_l |=> conv_start_out && !conv_group_b_out)
        else $error("rising edge did not start group a");
    a_fall_group_b: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        fall_l |=> conv_start_out && conv_group_b_out)
        else $error("falling edge did not start group b");
    a_conv_reset: assert property (@(posedge sys_clk_in)
        $rose(rst_n) |-> cfg_r.clock_div == CLK_DIV_RST && cfg_r.control == CONV_CTRL_RST
        && cfg_r.strobe == STROBE_RST && cfg_r.header_bits == HEADER_RST && !cfg_r.utos)
        else $error("converter settings wrong after reset");
    a_io_reset: assert property (@(posedge sys_clk_in)
        $rose(rst_n) |-> io_oe_out == IO_DIR_RST && io_pol_r == IO_POL_RST
        && io_ctrl_r == IO_CTRL_RST)
        else $error("io settings wrong after reset");
    a_filter_write: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        bus_wr_in && unit_sel && ofs == OFS_FILTER && io_dir_r[15:0] == 16'hffff
        && io_pol_r[15:0] == 16'h0 |=> filter_code_out == $past(bus_wdata_in[15:0]))
        else $error("filter code not driven from written word");
    a_foreign_unit: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        bus_rd_in && !unit_sel |=> bus_rdata_out == 32'h0)
        else $error("foreign unit read answered");
    a_switch_taken: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        sw_sync_r[2] == sw_sync_r[1] |=> unit_r == $past(sw_sync_r[2]))
        else $error("unit index not taken from switch");
    // A group loaded while busy would be lost without trace
    a_load_not_busy: assert property (@(posedge link_clk_in) disable iff (!link_rst_n)
        xfer_load |-> !xfer_busy)
        else $error("group loaded while crossing busy");
endmodule // aic_capture_top

/* rtl/aic_capture_top_fix.sv */
// Holds no logic; the capture block is built in aic_capture_top

/* rtl/aic_pkg.sv */
// Constants, types and register map of the analog input capture block
// Contract
// - Span maps onto codes 80d2 to 7f2e
// - Negative inputs coded in two's complement
// - Sample in result bits 31:16, slot mapping
// - Inputs 0,1,4,5 start on phase rise
// - Inputs 2,3,6,7 start on phase fall
// - Converter settings reset to required values
// - Io direction, polarity, control reset values
// - Two-bit code picks one of four cut-offs
// - Input n code at bits 2n, 2n+1
// - One unit sources servo and phase clocks; every unit drives them from reset until its switch is taken
// - Address switch index selects register set
package aic_pkg;
    localparam int NUM_INPUTS = 8;
    localparam int GROUP_SIZE = 4;
    localparam int SAMPLE_W = 16;
    localparam int RESULT_LSB = 16;
    localparam int ADDR_W = 12;
    localparam int UNIT_LSB = 8;
    localparam int UNIT_W = 4;
    localparam int FILTER_BITS = 16;

    // Byte offsets inside one unit's register set
    localparam logic [7:0] OFS_SAMPLE0 = 8'h00;
    localparam logic [7:0] OFS_FILTER = 8'h20;
    localparam logic [7:0] OFS_IO_DIR = 8'h24;
    localparam logic [7:0] OFS_IO_POL = 8'h28;
    localparam logic [7:0] OFS_IO_CTRL = 8'h2c;
    localparam logic [7:0] OFS_CLK_DIV = 8'h30;
    localparam logic [7:0] OFS_CONV_CTRL = 8'h34;
    localparam logic [7:0] OFS_STROBE = 8'h38;
    localparam logic [7:0] OFS_HEADER = 8'h3c;
    localparam logic [7:0] OFS_DELAY = 8'h40;
    localparam logic [7:0] OFS_UTOS = 8'h44;
    localparam logic [7:0] OFS_CLK_SRC = 8'h48;
    localparam logic [7:0] OFS_STATUS = 8'h4c;

    localparam logic [15:0] CODE_MIN = 16'h80d2;
    localparam logic [15:0] CODE_MAX = 16'h7f2e;

    localparam logic [7:0] CLK_DIV_RST = 8'h05;
    localparam logic [31:0] CONV_CTRL_RST = 32'h0ffffc01;
    localparam logic [31:0] STROBE_RST = 32'h000ffffc;
    localparam logic [7:0] HEADER_RST = 8'h01;
    localparam logic [7:0] DELAY_RST = 8'h00;
    localparam logic UTOS_RST = 1'b0;
    localparam logic [31:0] IO_DIR_RST = 32'h0000ffff;
    localparam logic [31:0] IO_POL_RST = 32'h00000000;
    localparam logic [31:0] IO_CTRL_RST = 32'h00000000;
    localparam logic [3:0] CLK_SRC_RST = 4'h0;

    // Status word fields
    localparam int ST_UNIT_LSB = 0;
    localparam int ST_SOURCE_BIT = 4;
    localparam int ST_PHASE_BIT = 5;

    // Phase clock made when this unit is the source
    localparam int SYS_CLK_MHZ = 250;
    localparam int PHASE_PERIOD_US = 200;
    localparam int PHASE_HALF_CYCLES_DEF = PHASE_PERIOD_US * SYS_CLK_MHZ / 2;
    localparam int SERVO_PHASES_DEF = 4;

    // Cut-off chosen by a two-bit code, in code order
    typedef enum logic [1:0] {CUT_3K2, CUT_4K3, CUT_12K2, CUT_24K5} aic_cutoff_t;

    typedef struct packed {
        logic [7:0] clock_div;
        logic [31:0] control;
        logic [31:0] strobe;
        logic [7:0] header_bits;
        logic [7:0] delay;
        logic utos;
    } aic_conv_cfg_t;

    typedef struct packed {
        logic group_b;
        logic [GROUP_SIZE-1:0][SAMPLE_W-1:0] data;
    } aic_group_t;

    function automatic logic [2:0] input_of(logic group_b, logic [1:0] slot);
        return {slot[1], group_b, slot[0]};
    endfunction

    function automatic logic [15:0] condition_code(logic [15:0] raw, logic utos);
        logic signed [15:0] v;
        v = utos ? {~raw[15], raw[14:0]} : raw;
        if (v < $signed(CODE_MIN))
            return CODE_MIN;
        if (v > $signed(CODE_MAX))
            return CODE_MAX;
        return v;
    endfunction
endpackage

/* rtl/aic_pulse_sync.sv */
// Toggle crossing of a one-cycle event into another clock
`timescale 1ns/100ps
module aic_pulse_sync (
    input wire logic src_clk_in,
    input wire logic src_rst_n_in,
    input wire logic src_pulse_in,
    input wire logic dst_clk_in,
    input wire logic dst_rst_n_in,
    output logic dst_pulse_out
);
    logic tog_r;
    logic [2:0] sync_r;

    always_ff @(posedge src_clk_in or negedge src_rst_n_in) begin
        if (!src_rst_n_in)
            tog_r <= 1'b0;
        else if (src_pulse_in)
            tog_r <= ~tog_r;
    end

    always_ff @(posedge dst_clk_in or negedge dst_rst_n_in) begin
        if (!dst_rst_n_in)
            sync_r <= 3'h0;
        else
            sync_r <= {sync_r[1:0], tog_r};
    end

    // Two events within one destination cycle cancel and give no pulse
    assign dst_pulse_out = sync_r[2] ^ sync_r[1];
endmodule // aic_pulse_sync

/* rtl/aic_word_xfer.sv */
// Request/acknowledge crossing of one data word
`timescale 1ns/100ps
module aic_word_xfer #(
    parameter int W = 65
) (
    input wire logic src_clk_in,
    input wire logic src_rst_n_in,
    input wire logic src_load_in,
    input wire logic [W-1:0] src_data_in,
    output logic src_busy_out,
    input wire logic dst_clk_in,
    input wire logic dst_rst_n_in,
    output logic dst_valid_out,
    output logic [W-1:0] dst_data_out
);
    logic req_r;
    logic [W-1:0] hold_r;
    logic [2:0] ack_sync_r;
    logic [2:0] req_sync_r;

    always_ff @(posedge src_clk_in or negedge src_rst_n_in) begin
        if (!src_rst_n_in) begin
            req_r <= 1'b0;
            hold_r <= '0;
            ack_sync_r <= 3'h0;
        end else begin
            ack_sync_r <= {ack_sync_r[1:0], req_sync_r[2]};
            if (src_load_in && !src_busy_out) begin
                req_r <= ~req_r;
                hold_r <= src_data_in;
            end
        end
    end

    // Hold word stays put until the far side has taken it
    assign src_busy_out = req_r ^ ack_sync_r[2];

    always_ff @(posedge dst_clk_in or negedge dst_rst_n_in) begin
        if (!dst_rst_n_in) begin
            req_sync_r <= 3'h0;
            dst_valid_out <= 1'b0;
            dst_data_out <= '0;
        end else begin
            req_sync_r <= {req_sync_r[1:0], req_r};
            dst_valid_out <= req_sync_r[2] ^ req_sync_r[1];
            if (req_sync_r[2] ^ req_sync_r[1])
                dst_data_out <= hold_r;
        end
    end
endmodule // aic_word_xfer

/* sim/aic_conv_model.sv */
// Behavioural converter at the far side of the conversion link
`timescale 1ns/100ps
module aic_conv_model (
    input wire logic link_clk_in,
    input wire logic start_in,
    input wire logic group_b_in,
    input wire logic [3:0] gap_in,
    input wire logic [7:0][15:0] raw_in,
    output logic valid_out,
    output logic [1:0] slot_out,
    output logic [15:0] data_out
);
    logic [2:0] sent = 3'h4;
    logic [3:0] wait_c = 4'h0;
    logic gb = 1'b0;
    initial valid_out = 1'b0;
    initial slot_out = 2'h0;
    initial data_out = 16'h5a5a;
    // Slots go out in reverse order; idle data keeps changing
    always @(posedge link_clk_in) begin
        valid_out <= 1'b0;
        data_out <= ~data_out;
        if (start_in) begin
            gb <= group_b_in;
            wait_c <= gap_in;
            sent <= 3'h0;
        end else if (wait_c != 4'h0) begin
            wait_c <= wait_c - 4'h1;
        end else if (sent < 3'h4) begin
            valid_out <= 1'b1;
            slot_out <= ~sent[1:0];
            data_out <= raw_in[{~sent[1], gb, ~sent[0]}];
            sent <= sent + 3'h1;
        end
    end
endmodule // aic_conv_model

/* sim/tb_top.sv */
// Self-checking bench for the analog input capture block
`timescale 1ns/100ps
module tb_top;
    import aic_pkg::*;
    localparam logic [7:0] OFS [10] = '{OFS_FILTER, OFS_IO_DIR, OFS_IO_POL, OFS_IO_CTRL,
        OFS_CLK_DIV, OFS_CONV_CTRL, OFS_STROBE, OFS_HEADER, OFS_DELAY, OFS_UTOS};
    localparam logic [31:0] RST_V [10] = '{32'h0, 32'h0000ffff, 32'h0, 32'h0, 32'h5,
        32'h0ffffc01, 32'h000ffffc, 32'h1, 32'h0, 32'h0};
    logic sys_clk_in = 1'b0;
    logic link_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [ADDR_W-1:0] bus_addr_in = '0;
    logic [31:0] bus_wdata_in = '0;
    logic bus_wr_in = 1'b0;
    logic bus_rd_in = 1'b0;
    logic [31:0] bus_rdata_out, io_data_out, io_oe_out, fw;
    logic [3:0] unit = 4'h0;
    logic phase_drv = 1'b0;
    logic phase_clk_out, phase_clk_oe_out, servo_clk_out, servo_clk_oe_out;
    logic [15:0] filter_code_out, conv_data_in;
    aic_conv_cfg_t conv_cfg_out;
    logic conv_start_out, conv_group_b_out, conv_valid_in, gb;
    logic [1:0] conv_slot_in;
    logic [3:0] gap = 4'h0;
    logic [7:0][15:0] raw = '0;
    logic [31:0] exp_res [8] = '{default: 32'h0};
    logic [31:0] rq [$];
    logic gq [$];
    logic rd_d = 1'b0;
    logic track = 1'b0;
    int err_count = 0;
    int n_checks = 0;
    int seed_r;
    int hi_s = 0;
    int hi_p = 0;

    always #2 sys_clk_in = ~sys_clk_in;
    initial begin
        #1.1;
        forever #7.5 link_clk_in = ~link_clk_in;
    end

    aic_capture_top #(.PHASE_HALF_CYCLES(20), .SERVO_PHASES(4)) aic_capture_top_i (
        .sys_clk_in, .rst_n_in, .bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in,
        .bus_rdata_out, .addr_switch_in(unit),
        .phase_clk_in(phase_clk_oe_out ? phase_clk_out : phase_drv),
        .phase_clk_out, .phase_clk_oe_out, .servo_clk_out, .servo_clk_oe_out,
        .filter_code_out, .io_data_out, .io_oe_out, .conv_cfg_out, .link_clk_in,
        .conv_start_out, .conv_group_b_out, .conv_valid_in, .conv_slot_in, .conv_data_in);

    aic_conv_model aic_conv_model_i (.link_clk_in, .start_in(conv_start_out),
        .group_b_in(conv_group_b_out), .gap_in(gap), .raw_in(raw),
        .valid_out(conv_valid_in), .slot_out(conv_slot_in), .data_out(conv_data_in));

    function automatic logic [15:0] sat(input logic [15:0] r);
        if ($signed(r) < -32558)
            return 16'h80d2;
        if ($signed(r) > 32558)
            return 16'h7f2e;
        return r;
    endfunction

    task automatic chk(input logic [127:0] got, input logic [127:0] e);
        n_checks++;
        if (got !== e) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, e);
        end
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        @(posedge sys_clk_in);
        bus_addr_in <= {unit, ofs};
        bus_wdata_in <= d;
        bus_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        bus_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] u, input logic [7:0] ofs, input logic [31:0] e);
        rq.push_back(e);
        @(posedge sys_clk_in);
        bus_addr_in <= {u, ofs};
        bus_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        bus_rd_in <= 1'b0;
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk_in) begin
        if (rd_d)
            chk(bus_rdata_out, (rq.size() > 0) ? rq.pop_front() : 32'hx);
        rd_d <= bus_rd_in;
    end

    always @(posedge link_clk_in)
        if (track && conv_start_out)
            chk(conv_group_b_out, (gq.size() > 0) ? gq.pop_front() : 1'bx);

    initial begin
        repeat (40000) @(posedge sys_clk_in);
        err_count++;
        report_and_stop();
    end

    initial begin
        seed_r = $urandom(32'he79963e3);
        unit <= 4'($urandom_range(15, 1));
        repeat (3) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (10) @(posedge sys_clk_in);
        chk(phase_clk_oe_out, 1'b0);
        chk(servo_clk_oe_out, 1'b0);
        chk(conv_cfg_out, {8'h05, 32'h0ffffc01, 32'h000ffffc, 8'h01, 8'h00, 1'b0});
        chk(io_oe_out, 32'h0000ffff);
        for (int i = 0; i < 10; i++)
            rd(unit, OFS[i], RST_V[i]);
        rd(unit, OFS_STATUS, {28'h0, unit});
        rd(unit + 4'h1, OFS_IO_DIR, 32'h0);
        rd(unit, 8'h80, 32'h0);
        wr(OFS_SAMPLE0, 32'hffffffff);
        rd(unit, OFS_SAMPLE0, 32'h0);
        for (int c = 0; c < 5; c++) begin
            fw = (c < 4) ? {16'h0, {8{2'(c)}}} : $urandom;
            wr(OFS_FILTER, fw);
            rd(unit, OFS_FILTER, fw);
            @(posedge sys_clk_in);
            chk(filter_code_out, fw[15:0]);
            chk(io_data_out, fw);
        end
        wr(OFS_CLK_SRC, {28'h0, unit});
        repeat (6) @(posedge sys_clk_in);
        chk(phase_clk_oe_out, 1'b1);
        chk(servo_clk_oe_out, 1'b1);
        // Any window of one servo period holds one high phase period
        for (int k = 0; k < 160; k++) begin
            @(posedge sys_clk_in);
            hi_s += servo_clk_out;
            hi_p += (k < 40) ? phase_clk_out : 1'b0;
        end
        chk(hi_s, 40);
        chk(hi_p, 20);
        wr(OFS_CLK_SRC, 32'h0);
        repeat (200) @(posedge sys_clk_in);
        chk(phase_clk_oe_out, 1'b0);
        track <= 1'b1;
        // First two edges carry the span limits and just beyond them
        for (int r = 0; r < 10; r++) begin
            if (r == 9)
                wr(OFS_UTOS, 32'h1);
            raw <= (r < 2) ? 128'h8000_7fff_80d1_7f2f_80d2_7f2e_ffff_0001
                : {$urandom, $urandom, $urandom, $urandom};
            gap <= 4'($urandom_range(6, 0));
            gb = phase_drv;
            phase_drv <= ~phase_drv;
            gq.push_back(gb);
            repeat (120) @(posedge sys_clk_in);
            for (int i = 0; i < 8; i++) begin
                if (i[1] == gb)
                    exp_res[i] = {sat(raw[i] ^ {r == 9, 15'h0}), 16'h0};
                rd(unit, OFS_SAMPLE0 + 8'(4 * i), exp_res[i]);
            end
        end
        track <= 1'b0;
        for (int k = 0; k < 50 && rq.size() > 0; k++)
            @(posedge sys_clk_in);
        if (rq.size() > 0 || gq.size() > 0)
            err_count++;
        report_and_stop();
    end
endmodule // tb_top
